//--- rtl/gdfhc_dev.sv
// Driver core supervision: power-on wait, supply ramp reset, trips,
// pulse filtering, fault latch with recovery timer, halt handshake.
// Assumes all trip and fault flags are synchronous and active high.
//
// Functional notes
// R1 - Ready about 150 ms after supply on
// R2 - Controller keeps inputs low until reset ends
// R3 - Status goes low after reset without error
// R4 - Supply-good low holds initial reset state
// R5 - Supply-good is not a halt control
// R6 - Primary undervoltage forces off, status high
// R7 - Secondary undervoltage forces off, status high
// R8 - Switching inputs are active high
// R9 - Controller pulses never shorter than 1 us
// R10 - Filter drops under 625 ns, passes 750
// R11 - Any failure latches status, gates off
// R12 - Failure starts a 3 s recovery timer
// R13 - Recover after timer, quiet inputs, no supply fault
// R14 - External errors ignored until first pulse
// R15 - Halt input high switches gates off
// R16 - Halt never sets status; release re-enables
// R17 - Status output is wired to halt input
// R18 - Status low ready, high not ready
// R19 - Timings counted on clock, lengths parameterised
`timescale 1ns/1ps
module gdfhc_dev
   import gdfhc_pkg::*;
#(
   parameter int POR_CYCLES = POR_CYC,
   parameter int RECOV_CYCLES = RECOV_CYC,
   parameter int LOW_CYCLES = LOW_CYC,
   parameter int FILT_CYCLES = FILT_CYC
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   gdfhc_if.dev lnk,
   input wire logic i_prim_uv_trip,
   input wire logic i_high_side_uv_trip,
   input wire logic i_low_side_uv_trip,
   input wire logic i_high_side_desat,
   input wire logic i_low_side_desat,
   input wire logic i_high_side_ext_fault,
   input wire logic i_low_side_ext_fault,
   output logic o_high_side_gate_on,
   output logic o_high_side_gate_off,
   output logic o_low_side_gate_on,
   output logic o_low_side_gate_off,
   output logic [CAUSE_W-1:0] o_fault_cause
);

   // ==========================================================
   // Saturating counter step
   function automatic logic [CNT_W-1:0] sat_inc(
      input logic [CNT_W-1:0] cnt,
      input int lim
   );
      sat_inc = (cnt >= CNT_W'(lim)) ? cnt : cnt + 1'b1;
   endfunction

   // ==========================================================
   // Input filtering
   logic filt_high;
   logic filt_low;

   gdfhc_filt #(
      .CYC(FILT_CYCLES)
   ) u_filt_high (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_in(lnk.high_side_switch_cmd),
      .o_out(filt_high)
   ); // R10

   gdfhc_filt #(
      .CYC(FILT_CYCLES)
   ) u_filt_low (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_in(lnk.low_side_switch_cmd),
      .o_out(filt_low)
   ); // R10

   // ==========================================================
   // State and counters
   gdfhc_state_t state_q;
   gdfhc_state_t state_d;
   logic [CNT_W-1:0] por_cnt_q;
   logic [CNT_W-1:0] por_cnt_d;
   logic [CNT_W-1:0] rec_cnt_q;
   logic [CNT_W-1:0] rec_cnt_d;
   logic [CNT_W-1:0] low_cnt_q;
   logic [CNT_W-1:0] low_cnt_d;
   logic armed_q;
   logic armed_d;
   logic status_q;
   logic high_on_q;
   logic low_on_q;
   logic [CAUSE_W-1:0] cause_q;
   logic [CAUSE_W-1:0] cause_d;

   // ==========================================================
   // Failure decode
   wire supply_fail = !lnk.supply_good_in;
   wire uv_fail = i_prim_uv_trip | i_high_side_uv_trip
      | i_low_side_uv_trip; // R6 R7
   // Fails that must be gone before recovery
   wire hard_fail = supply_fail | uv_fail; // R13
   wire desat_fail = i_high_side_desat | i_low_side_desat;
   // Error inputs only watched once a pulse went through
   wire ext_fail = armed_q
      & (i_high_side_ext_fault | i_low_side_ext_fault); // R14
   wire any_fail = hard_fail | desat_fail | ext_fail; // R11

   wire por_done = por_cnt_q == CNT_W'(POR_CYCLES); // R1
   wire rec_done = rec_cnt_q == CNT_W'(RECOV_CYCLES); // R12
   wire low_done = low_cnt_q == CNT_W'(LOW_CYCLES); // R13
   wire inputs_low = !filt_high && !filt_low;
   wire in_run = state_q == ST_RUN;
   wire in_fault = state_q == ST_FAULT;
   wire in_por = state_q == ST_POR;

   // Gates only pass when running, not halted, no new failure
   wire pass = in_run && !lnk.halt_in && !any_fail; // R15 R16
   wire high_on_d = pass && filt_high; // R8
   wire low_on_d = pass && filt_low; // R8

   wire [CAUSE_W-1:0] cause_now = {
      1'b0,
      ext_fail,
      desat_fail,
      uv_fail,
      supply_fail
   };

   // ==========================================================
   // Next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_POR: begin
            if (por_done) begin
               state_d = any_fail ? ST_FAULT : ST_RUN; // R3
            end
         end
         ST_RUN: begin
            if (any_fail) begin
               state_d = ST_FAULT; // R11
            end
         end
         ST_FAULT: begin
            if (rec_done && low_done && !hard_fail) begin
               state_d = ST_RUN; // R13
            end
         end
      endcase
   end

   // ==========================================================
   // Counter and flag next values
   always_comb begin
      // Supply-good low keeps the power-on wait at its start
      if (in_por && !supply_fail) begin
         por_cnt_d = sat_inc(por_cnt_q, POR_CYCLES); // R19
      end else if (in_por) begin
         por_cnt_d = '0; // R4
      end else begin
         por_cnt_d = por_cnt_q;
      end
      rec_cnt_d = in_fault ? sat_inc(rec_cnt_q, RECOV_CYCLES) : '0; // R12
      low_cnt_d = (in_fault && inputs_low)
         ? sat_inc(low_cnt_q, LOW_CYCLES) : '0; // R13
      armed_d = armed_q;
      if (state_d != ST_RUN) begin
         armed_d = 1'b0; // R14
      end else if (high_on_d || low_on_d) begin
         armed_d = 1'b1; // R14
      end
      cause_d = cause_q;
      if (state_d == ST_FAULT && !in_fault) begin
         cause_d = cause_now;
         cause_d[CAUSE_POR] = in_por;
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         state_q <= ST_POR;
         por_cnt_q <= '0;
         rec_cnt_q <= '0;
         low_cnt_q <= '0;
         armed_q <= 1'b0;
         status_q <= 1'b1;
         high_on_q <= 1'b0;
         low_on_q <= 1'b0;
         cause_q <= '0;
      end else begin
         state_q <= state_d;
         por_cnt_q <= por_cnt_d;
         rec_cnt_q <= rec_cnt_d;
         low_cnt_q <= low_cnt_d;
         armed_q <= armed_d;
         // Halt plays no part here
         status_q <= state_d != ST_RUN; // R18 R16
         high_on_q <= high_on_d; // R6 R7 R11
         low_on_q <= low_on_d; // R6 R7 R11
         cause_q <= cause_d;
      end
   end

   // ==========================================================
   // Outputs
   assign lnk.status_out = status_q;
   assign o_high_side_gate_on = high_on_q;
   assign o_low_side_gate_on = low_on_q;
   // Off drive is the exact complement, never both low
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_high_side_gate_off <= 1'b1;
         o_low_side_gate_off <= 1'b1;
      end else begin
         o_high_side_gate_off <= !high_on_d;
         o_low_side_gate_off <= !low_on_d;
      end
   end
   assign o_fault_cause = cause_q;
endmodule

//--- inc/gdfhc_pkg.sv
// Package: constants shared by both ends of the gate driver supervision link.
// Assumes a single 20 MHz clock on both ends.
package gdfhc_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CLK_NS = 50;
   localparam int POR_MS = 150;
   localparam int POR_CYC = POR_MS * (1000000 / CLK_NS);
   localparam int RECOV_S = 3;
   localparam int RECOV_CYC = RECOV_S * 1000 * (1000000 / CLK_NS);
   localparam int LOW_NS = 9000;
   // Strictly longer than the low time, hence one extra cycle
   localparam int LOW_CYC = LOW_NS / CLK_NS + 1;
   localparam int REJECT_NS = 625;
   localparam int PASS_NS = 750;
   localparam int FILT_CYC = (REJECT_NS + CLK_NS - 1) / CLK_NS;
   localparam int MIN_PULSE_NS = 1000;
   localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 32;

   // ==========================================================
   // Controller register map (APB)
   localparam int ADDR_W = 8;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam int CTRL_SUPPLY_BIT = 0;
   localparam int CTRL_HALT_BIT = 1;
   localparam int CTRL_HIGH_BIT = 2;
   localparam int CTRL_LOW_BIT = 3;
   localparam int CTRL_W = 4;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam int STAT_STATUS_BIT = 0;
   localparam int STAT_HIGH_BIT = 1;
   localparam int STAT_LOW_BIT = 2;
   localparam int STAT_HALT_BIT = 3;

   // ==========================================================
   // Device states and fault cause bits
   typedef enum logic [1:0] {ST_POR, ST_RUN, ST_FAULT} gdfhc_state_t;
   localparam int CAUSE_W = 5;
   localparam int CAUSE_SUPPLY = 0;
   localparam int CAUSE_UV = 1;
   localparam int CAUSE_DESAT = 2;
   localparam int CAUSE_EXT = 3;
   localparam int CAUSE_POR = 4;
endpackage

//--- inc/gdfhc_if.sv
// Interface: primary-side link between controller and driver core.
// Both ends share one clock; every signal is driven from a flip-flop.
`timescale 1ns/1ps
interface gdfhc_if;
   logic supply_good_in;
   logic high_side_switch_cmd;
   logic low_side_switch_cmd;
   logic halt_in;
   logic status_out;

   modport dev (
      input supply_good_in,
      input high_side_switch_cmd,
      input low_side_switch_cmd,
      input halt_in,
      output status_out
   );

   modport ctl (
      output supply_good_in,
      output high_side_switch_cmd,
      output low_side_switch_cmd,
      output halt_in,
      input status_out
   );
endinterface

//--- rtl/gdfhc_filt.sv
// Short pulse suppressor for one switching input.
// Input is synchronous to i_clk; output moves only after CYC stable cycles.
`timescale 1ns/1ps
module gdfhc_filt
   import gdfhc_pkg::*;
#(
   parameter int CYC = FILT_CYC
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_in,
   output logic o_out
);

   // ==========================================================
   // Stability counter
   logic [CNT_W-1:0] cnt_q;
   logic out_q;
   wire differs = i_in != out_q;
   wire settled = differs && (cnt_q == CNT_W'(CYC - 1));

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         cnt_q <= '0;
         out_q <= 1'b0;
      end else begin
         // Any return to the old level restarts the count
         cnt_q <= (differs && !settled) ? cnt_q + 1'b1 : '0;
         if (settled) begin
            out_q <= i_in;
         end
      end
   end

   assign o_out = out_q;
endmodule

//--- rtl/gdfhc_ctl.sv
// Controller end: APB register slave that drives the driver link.
// Assumes APB on the same clock as the link; zero-wait-state slave.
`timescale 1ns/1ps
module gdfhc_ctl
   import gdfhc_pkg::*;
#(
   parameter int MIN_PULSE = MIN_PULSE_CYC
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   gdfhc_if.ctl lnk
);

   // ==========================================================
   // APB decode
   logic [CTRL_W-1:0] ctrl_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic halt_q;
   logic [1:0] cmd_q;
   logic [CNT_W-1:0] hold_q [2];

   wire setup = i_psel && !i_penable;
   wire hit_ctrl = i_paddr == CTRL_OFS;
   wire hit_stat = i_paddr == STAT_OFS;
   wire mapped = hit_ctrl || hit_stat;
   wire wr_ctrl = i_psel && i_penable && pready_q && i_pwrite && hit_ctrl;
   wire [31:0] rd_mux = hit_ctrl ? 32'(ctrl_q) : hit_stat ? 32'({
      halt_q,
      cmd_q[1],
      cmd_q[0],
      lnk.status_out
   }) : '0;

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         ctrl_q <= CTRL_RST;
         prdata_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup && !mapped;
         prdata_q <= (setup && !i_pwrite) ? rd_mux : '0;
         if (wr_ctrl) begin
            ctrl_q <= i_pwdata[CTRL_W-1:0];
         end
      end
   end

   // ==========================================================
   // Link drive
   // Commands forced low, after their minimum pulse time, while the driver reports not ready
   wire ok = !lnk.status_out; // R2 R13
   wire [1:0] want = {
      ctrl_q[CTRL_LOW_BIT] && ok,
      ctrl_q[CTRL_HIGH_BIT] && ok
   };

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         halt_q <= 1'b1;
         cmd_q <= '0;
         for (int i = 0; i < 2; i++) begin
            hold_q[i] <= '0;
         end
      end else begin
         // Status looped back so a latched failure halts too
         halt_q <= lnk.status_out || ctrl_q[CTRL_HALT_BIT]; // R17
         for (int i = 0; i < 2; i++) begin
            // Each level is kept at least the minimum pulse time
            if (hold_q[i] != '0) begin
               hold_q[i] <= hold_q[i] - 1'b1; // R9
            end else if (want[i] != cmd_q[i]) begin
               cmd_q[i] <= want[i];
               hold_q[i] <= CNT_W'(MIN_PULSE - 1); // R9
            end
         end
      end
   end

   // Supply-good is its own bit, never tied to halt
   assign lnk.supply_good_in = ctrl_q[CTRL_SUPPLY_BIT]; // R5
   assign lnk.halt_in = halt_q;
   assign lnk.high_side_switch_cmd = cmd_q[0];
   assign lnk.low_side_switch_cmd = cmd_q[1];
   assign o_prdata = prdata_q;
   assign o_pready = pready_q;
   assign o_pslverr = pslverr_q;
endmodule

//--- test/gdfhc_sva.sv
// Checker: link-level assertions between controller end and driver core.
// Assumes one clock; instantiated beside the link interface, not bound.
`timescale 1ns/1ps
module gdfhc_sva #(
   parameter int POR_CYCLES = 50
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic supply_good_in,
   input wire logic high_side_switch_cmd,
   input wire logic low_side_switch_cmd,
   input wire logic halt_in,
   input wire logic status_out,
   input wire logic o_high_side_gate_on,
   input wire logic o_low_side_gate_on
);
   // ==========================================================
   // Helper: cycles spent not ready
   logic [31:0] busy_cnt_q;
   logic [31:0] busy_cnt_d;
   assign busy_cnt_d = status_out ? busy_cnt_q + 32'h1 : 32'h0;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         busy_cnt_q <= 32'h0;
      end else begin
         busy_cnt_q <= busy_cnt_d;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // ==========================================================
   // Assertions
   a_reset_not_ready: assert property (
      $rose(i_resetn) |-> status_out && halt_in)
      else $error("status or halt low right after reset");
   a_ready_min_wait: assert property (
      $fell(status_out) |-> busy_cnt_q >= POR_CYCLES)
      else $error("ready before wait elapsed");
   a_supply_low_busy: assert property (
      !supply_good_in |=> status_out)
      else $error("supply low but status ready");
   a_status_gates_off: assert property (
      status_out |-> !o_high_side_gate_on && !o_low_side_gate_on)
      else $error("gate on while not ready");
   a_halt_gates_off: assert property (
      halt_in |=> !o_high_side_gate_on && !o_low_side_gate_on)
      else $error("gate on during halt");
   a_halt_no_status: assert property (
      halt_in && !status_out |=> !status_out)
      else $error("halt raised status");
   a_high_gate_filt: assert property (
      $rose(o_high_side_gate_on) |-> $past(high_side_switch_cmd, 1)
      && $past(high_side_switch_cmd, 12))
      else $error("high gate rose without stable command");
   a_low_gate_filt: assert property (
      $rose(o_low_side_gate_on) |-> $past(low_side_switch_cmd, 1)
      && $past(low_side_switch_cmd, 12))
      else $error("low gate rose without stable command");
   c_ready: cover property ($fell(status_out));
   c_high_gate: cover property ($rose(o_high_side_gate_on));
   c_sw_halt: cover property (halt_in && !status_out);
endmodule

//--- test/tb_top.sv
// Testbench: controller end and driver core joined by the link interface.
// Assumes shortened wait, recovery and quiet-time counts on the core.
`timescale 1ns/1ps
module tb_top;
   import gdfhc_pkg::*;
   localparam int POR = 50;
   localparam int RECOV = 100;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr, berr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [6:0] flt;
   logic hi_on, hi_off, lo_on, lo_off;
   logic [CAUSE_W-1:0] cause;
   logic [2:0] obs;
   int n_fail, check_count;
   gdfhc_if link();
   assign obs = {lo_on, hi_on, link.status_out};
   gdfhc_ctl gdfhc_ctl_inst(.i_clk(clk), .i_resetn(resetn), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .lnk(link));
   gdfhc_dev #(.POR_CYCLES(POR), .RECOV_CYCLES(RECOV), .LOW_CYCLES(20))
      gdfhc_dev_inst(.i_clk(clk), .i_resetn(resetn), .lnk(link),
      .i_prim_uv_trip(flt[0]), .i_high_side_uv_trip(flt[1]),
      .i_low_side_uv_trip(flt[2]), .i_high_side_desat(flt[3]),
      .i_low_side_desat(flt[4]), .i_high_side_ext_fault(flt[5]),
      .i_low_side_ext_fault(flt[6]), .o_high_side_gate_on(hi_on),
      .o_high_side_gate_off(hi_off), .o_low_side_gate_on(lo_on),
      .o_low_side_gate_off(lo_off), .o_fault_cause(cause));
   gdfhc_sva #(.POR_CYCLES(POR)) gdfhc_sva_inst(.i_clk(clk),
      .i_resetn(resetn), .supply_good_in(link.supply_good_in),
      .high_side_switch_cmd(link.high_side_switch_cmd),
      .low_side_switch_cmd(link.low_side_switch_cmd),
      .halt_in(link.halt_in), .status_out(link.status_out),
      .o_high_side_gate_on(hi_on), .o_low_side_gate_on(lo_on));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ==========================================================
   // Shared tasks
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Reads settle pre-edge values, so no race with the slave flops
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      berr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wait_for(input int sel, input logic v, output int n);
      n = 0;
      while (obs[sel] !== v && n < 1000) begin
         @(posedge clk);
         n++;
      end
   endtask
   task drive(input logic [3:0] c, input int sel, input int lo, input int hi);
      int n;
      apb(1'b1, CTRL_OFS, {28'h0, c});
      if (sel != 0) begin
         wait_for(sel, 1'b1, n);
         chk("gate_delay", n >= lo && n <= hi, 1'b1);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task t_power_up;
      int n;
      chk("status_reset", link.status_out, 1'b1);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl_reset", rdat, 32'h0);
      apb(1'b1, CTRL_OFS, 32'h1);
      wait_for(0, 1'b0, n);
      chk("por_wait", n >= POR - 5 && n <= POR + 10, 1'b1);
      apb(1'b0, STAT_OFS, 32'h0);
      chk("ready_status", rdat, 32'h0);
   endtask
   task t_halt;
      drive(4'h5, 1, 11, 17);
      chk("low_idle", lo_on, 1'b0);
      chk("off_compl", hi_off, 1'b0);
      drive(4'h7, 0, 0, 0);
      repeat (3) @(posedge clk);
      chk("halt_gate", hi_on, 1'b0);
      chk("halt_status", link.status_out, 1'b0);
      drive(4'h5, 1, 0, 5);
      drive(4'h1, 0, 0, 0);
      // Controller keeps the last level for its minimum pulse time
      repeat (MIN_PULSE_CYC) @(posedge clk);
      chk("release_off", hi_on, 1'b0);
   endtask
   task fault_case(input int i, input int sel, input logic [4:0] exp);
      int n;
      drive(sel == 2 ? 4'h9 : 4'h5, sel, 11, 17);
      flt[i] <= 1'b1;
      repeat (2) @(posedge clk);
      flt[i] <= 1'b0;
      @(posedge clk);
      chk("fault_status", link.status_out, 1'b1);
      chk("fault_gates", hi_on | lo_on, 1'b0);
      chk("fault_off", {hi_off, lo_off}, 2'b11);
      chk("fault_cause", cause, exp);
      drive(4'h1, 0, 0, 0);
      wait_for(0, 1'b0, n);
      chk("recovery", n >= RECOV - 12 && n <= RECOV + 40, 1'b1);
   endtask
   task t_ext_rearm;
      int n;
      drive(4'h5, 1, 11, 17);
      flt[5] <= 1'b1;
      wait_for(0, 1'b1, n);
      drive(4'h1, 0, 0, 0);
      wait_for(0, 1'b0, n);
      chk("ext_ignored", n <= RECOV + 40, 1'b1);
      repeat (20) @(posedge clk);
      chk("no_redetect", link.status_out, 1'b0);
      drive(4'h5, 0, 0, 0);
      wait_for(0, 1'b1, n);
      chk("redetect", n >= 10 && n <= 22, 1'b1);
      flt[5] <= 1'b0;
      drive(4'h1, 0, 0, 0);
      wait_for(0, 1'b0, n);
   endtask
   task t_supply;
      int n;
      drive(4'h5, 1, 11, 17);
      drive(4'h4, 0, 0, 0);
      repeat (3) @(posedge clk);
      chk("supply_status", link.status_out, 1'b1);
      chk("supply_cause", cause, 5'h01);
      repeat (RECOV + 30) @(posedge clk);
      chk("supply_hold", link.status_out, 1'b1);
      drive(4'h1, 0, 0, 0);
      wait_for(0, 1'b0, n);
      chk("supply_back", n <= 80, 1'b1);
      apb(1'b0, 8'h08, 32'h0);
      chk("unmapped_err", {berr, rdat[30:0]}, 32'h80000000);
   endtask
   // Fault present as the power-on wait ends, after a second reset
   task t_por_fault;
      int n;
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      flt[3] <= 1'b1;
      @(posedge clk);
      chk("rst_status", link.status_out, 1'b1);
      chk("rst_cause", cause, 5'h00);
      apb(1'b1, CTRL_OFS, 32'h1);
      repeat (POR + 5) @(posedge clk);
      chk("por_fault", {link.status_out, cause}, 6'h34);
      flt[3] <= 1'b0;
      wait_for(0, 1'b0, n);
      chk("por_recover", n >= RECOV - 12 && n <= RECOV + 40, 1'b1);
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      {psel, penable, pwrite, paddr, pwdata, flt} = '0;
      resetn = 1'b0;
      n_fail = 0;
      check_count = 0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_power_up;
      t_halt;
      for (int i = 0; i < 7; i++) begin
         fault_case(i, (i % 2 == 0 && i > 0) ? 2 : 1,
            i < 3 ? 5'h02 : (i < 5 ? 5'h04 : 5'h08));
      end
      t_ext_rearm;
      t_supply;
      t_por_fault;
      print_verdict;
   end
   initial begin
      repeat (10000) @(posedge clk);
      n_fail++;
      print_verdict;
   end
endmodule
